/* design/ebl_pkg.sv */
package ebl_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int BOOT_WAIT_MS = 100;
  localparam int BOOT_WAIT_CYC = BOOT_WAIT_MS * 1000 * CLK_MHZ;
  localparam int SCL_QUARTER_NS = 625;
  localparam int LINK_PERIOD_PS = 12000;
  // least quarter of a 400 kHz bit, rounded up to whole link cycles
  localparam int SCL_QUARTER_CYC =
    (SCL_QUARTER_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam logic [3:0] STRAP_SETTLE = 4'h4;

  // ---------------------------------------------------------------------------
  // register image
  // ---------------------------------------------------------------------------
  localparam int REG_COUNT = 27;
  localparam logic [7:0] REG_LIMIT = 8'h1b;
  localparam logic [4:0] REG_SLAVE_DEVICE_COUNT = 5'h0f;
  localparam logic [4:0] REG_IMAGE_CHECKSUM_BYTE = 5'h1a;
  localparam logic [7:0] CHECKSUM_TARGET = 8'h2e;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] EEPROM_WORD_START = 8'h00;
  localparam logic [9:0] LAST_ATTEMPT = 10'h1ff;

  // ---------------------------------------------------------------------------
  // two-wire addressing
  // ---------------------------------------------------------------------------
  localparam logic [6:0] BOOT_SLAVE_ADDR = 7'h20;
  localparam logic [6:0] EEPROM_BASE_ADDR = 7'h50;
  localparam logic I2C_WRITE = 1'b0;
  localparam logic I2C_READ = 1'b1;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] TRI_LOW = 2'h0;
  localparam logic [1:0] TRI_HIGH = 2'h1;
  localparam logic [1:0] TRI_FLOAT = 2'h2;
  localparam logic [5:0] TRI_W2 = 6'h09;
  localparam logic [5:0] TRI_W1 = 6'h03;
  localparam logic [5:0] STRAP_BIT_THREE_FLOAT_WEIGHT = 6'h1b;
  localparam logic [5:0] SLAVE_INDEX_FIRST = 6'h09;
  localparam logic [5:0] SLAVE_INDEX_LAST = 6'h30;
  localparam logic [5:0] SLAVE_INDEX_BIAS = 6'h08;

endpackage

/* design/ebl_sync.sv */
`timescale 1ns/1ps
module ebl_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  if (W < 1) begin : g_chk
    $error("ebl_sync width must be at least one");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ebl_sync_s;

  ebl_sync_s r;
  ebl_sync_s next_r;

  always_comb begin
    next_r = r;
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // a bit changes only once the second and third stages agree
    next_r.q = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.q;

endmodule // ebl_sync

/* design/ebl_loader.sv */
`timescale 1ns/1ps
module ebl_loader #(
  parameter int BOOT_WAIT_CYCLES = ebl_pkg::BOOT_WAIT_CYC,
  parameter int QDIV = ebl_pkg::SCL_QUARTER_CYC
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic LINK_CLK_I,
  input wire logic TWO_WIRE_HOST_MODE_I,
  input wire logic [1:0] STRAP_BIT_ZERO_I,
  input wire logic [1:0] STRAP_BIT_ONE_I,
  input wire logic [1:0] STRAP_BIT_TWO_I,
  input wire logic [1:0] STRAP_BIT_THREE_I,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic EEPROM_BOOT_MODE_O,
  output logic BOOT_BUSY_O,
  output logic BOOT_DONE_O,
  output logic BOOT_TIMEOUT_O,
  output logic [6:0] SLAVE_ADDR_O,
  output logic [ebl_pkg::REG_COUNT*8-1:0] CONFIG_O
);

  if (QDIV < 2 || QDIV > 255) begin : g_chk_div
    $error("QDIV must lie between 2 and 255");
  end
  if (BOOT_WAIT_CYCLES < 1) begin : g_chk_wait
    $error("BOOT_WAIT_CYCLES must be at least one");
  end

  localparam logic [7:0] DIV_LAST = 8'(QDIV - 1);
  localparam logic [31:0] WAIT_LAST = 32'(BOOT_WAIT_CYCLES - 1);
  localparam logic [4:0] LAST_IDX = 5'(ebl_pkg::REG_COUNT - 1);

  typedef logic [ebl_pkg::REG_COUNT-1:0][7:0] ebl_image_t;

  // ---------------------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    B_STRAP = 4'h1,
    B_LOAD = 4'h2,
    B_WAIT = 4'h4,
    B_SLAVE = 4'h8
  } ebl_boot_e;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_ADDR = 4'h2,
    S_WRITE = 4'h4,
    S_READ = 4'h8
  } ebl_slave_e;

  typedef enum logic [4:0] {
    L_IDLE = 5'h01,
    L_START = 5'h02,
    L_TX = 5'h04,
    L_RX = 5'h08,
    L_STOP = 5'h10
  } ebl_link_e;

  typedef struct packed {
    ebl_boot_e bst;
    logic [3:0] settle;
    logic mode2w;
    logic boot;
    logic [1:0] sel;
    logic [6:0] addr;
    logic [31:0] wait_cnt;
    logic expired;
    logic [9:0] tries;
    logic req_tgl;
    logic done_seen;
    logic timeout;
    logic done;
    ebl_image_t regs;
    ebl_slave_e sst;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic first;
    logic rw;
    logic acked;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
  } ebl_main_s;

  typedef struct packed {
    ebl_link_e lst;
    logic [1:0] q;
    logic [7:0] div;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] phase;
    logic [4:0] idx;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic req_seen;
    logic done_tgl;
    ebl_image_t img;
  } ebl_link_s;

  ebl_main_s r;
  ebl_main_s next_r;
  ebl_link_s l;
  ebl_link_s next_l;

  // ---------------------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------------------
  function automatic logic [1:0] tri_digit(input logic [1:0] c);
    logic [1:0] d;
    d = 2'h2;
    if (c == ebl_pkg::TRI_LOW) d = 2'h0;
    else if (c == ebl_pkg::TRI_HIGH) d = 2'h1;
    return d;
  endfunction

  // {boot, memory select, slave address}
  function automatic logic [9:0] strap_decode(input logic [7:0] c);
    logic [5:0] v;
    logic [9:0] res;
    v = ((c[7:6] == ebl_pkg::TRI_LOW) ? 6'h00 : ebl_pkg::STRAP_BIT_THREE_FLOAT_WEIGHT)
      + ebl_pkg::TRI_W2 * {4'h0, tri_digit(c[5:4])}
      + ebl_pkg::TRI_W1 * {4'h0, tri_digit(c[3:2])}
      + {4'h0, tri_digit(c[1:0])};
    res = {1'b0, 2'h0, ebl_pkg::BOOT_SLAVE_ADDR};
    if (c[7:6] == ebl_pkg::TRI_LOW && c[5:4] == ebl_pkg::TRI_LOW &&
        c[3:2] != ebl_pkg::TRI_FLOAT && c[1:0] != ebl_pkg::TRI_FLOAT) begin
      res = {1'b1, c[2], c[0], ebl_pkg::BOOT_SLAVE_ADDR};
    end else if (v >= ebl_pkg::SLAVE_INDEX_FIRST &&
                 v <= ebl_pkg::SLAVE_INDEX_LAST) begin
      res = {1'b0, 2'h0, 7'(ebl_pkg::BOOT_SLAVE_ADDR
        + {1'b0, v - ebl_pkg::SLAVE_INDEX_BIAS})};
    end
    return res;
  endfunction

  function automatic logic [7:0] image_sum(input ebl_image_t im);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < ebl_pkg::REG_COUNT; i++) begin
      s = s + im[i];
    end
    return s;
  endfunction

  function automatic logic [7:0] reg_read(input ebl_image_t im,
                                          input logic [7:0] p);
    return (p < ebl_pkg::REG_LIMIT) ? im[p[4:0]] : 8'h00;
  endfunction

  function automatic logic slot_sda(input ebl_link_s s);
    logic d;
    case (s.lst)
      L_TX: d = (s.cnt != ebl_pkg::BIT_ACK) && !s.sh[7];
      L_RX: d = (s.cnt == ebl_pkg::BIT_ACK) && (s.idx != LAST_IDX);
      L_STOP: d = 1'b1;
      default: d = 1'b0;
    endcase
    return d;
  endfunction

  // ---------------------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------------------
  logic [11:0] sy_m;
  logic [1:0] sy_l;

  ebl_sync #(.W(12)) u_sync_main (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .d_i({TWO_WIRE_HOST_MODE_I, STRAP_BIT_THREE_I, STRAP_BIT_TWO_I,
          STRAP_BIT_ONE_I, STRAP_BIT_ZERO_I, SCL_I, SDA_I, l.done_tgl}),
    .q_o(sy_m)
  );

  ebl_sync #(.W(2)) u_sync_link (
    .clk_i(LINK_CLK_I),
    .rst_n_i(RESETN_I),
    .d_i({r.req_tgl, SDA_I}),
    .q_o(sy_l)
  );

  // ---------------------------------------------------------------------------
  // main domain: straps, boot sequence, slave port
  // ---------------------------------------------------------------------------
  logic [9:0] dec;
  logic scl_s, sda_s, start_c, stop_c, rise_c, fall_c, slave_on;

  always_comb begin
    next_r = r;
    dec = strap_decode(sy_m[10:3]);
    scl_s = sy_m[2];
    sda_s = sy_m[1];
    if (!r.expired) begin
      next_r.wait_cnt = r.wait_cnt + 32'h1;
      next_r.expired = (r.wait_cnt == WAIT_LAST);
    end
    case (r.bst)
      B_STRAP: begin
        next_r.settle = r.settle + 4'h1;
        if (r.settle == ebl_pkg::STRAP_SETTLE) begin
          next_r.mode2w = sy_m[11];
          next_r.boot = dec[9] & sy_m[11];
          next_r.sel = dec[8:7];
          next_r.addr = dec[6:0];
          next_r.bst = (dec[9] & sy_m[11]) ? B_LOAD : B_SLAVE;
        end
      end
      B_LOAD: begin
        next_r.req_tgl = ~r.req_tgl;
        next_r.bst = B_WAIT;
      end
      B_WAIT: begin
        if (sy_m[0] != r.done_seen) begin
          next_r.done_seen = sy_m[0];
          if (l.nack) begin
            if (r.expired) begin
              next_r.timeout = 1'b1;
              next_r.bst = B_SLAVE;
            end else begin
              next_r.bst = B_LOAD;
            end
          end else if (l.img[ebl_pkg::REG_SLAVE_DEVICE_COUNT] != 8'h00 &&
                       image_sum(l.img) != ebl_pkg::CHECKSUM_TARGET) begin
            // downloaded bytes are not taken over
            if (r.tries == ebl_pkg::LAST_ATTEMPT) begin
              next_r.timeout = 1'b1;
              next_r.bst = B_SLAVE;
            end else begin
              next_r.tries = r.tries + 10'h1;
              next_r.bst = B_LOAD;
            end
          end else begin
            next_r.regs = l.img;
            next_r.done = 1'b1;
            next_r.bst = B_SLAVE;
          end
        end
        // expiry alone never aborts: each attempt ends on its own answer,
        // so a checksum retry after the wait period still runs to the end
      end
      B_SLAVE: begin
      end
      default: next_r.bst = B_STRAP;
    endcase

    // slave port
    next_r.scl_q = scl_s;
    next_r.sda_q = sda_s;
    start_c = scl_s & r.scl_q & r.sda_q & ~sda_s;
    stop_c = scl_s & r.scl_q & ~r.sda_q & sda_s;
    rise_c = scl_s & ~r.scl_q;
    fall_c = ~scl_s & r.scl_q;
    slave_on = (r.bst == B_SLAVE) && r.mode2w;
    if (!slave_on || stop_c) begin
      next_r.sst = S_IDLE;
      next_r.sda_oe = 1'b0;
      next_r.acked = 1'b0;
    end else if (start_c) begin
      next_r.sst = S_ADDR;
      next_r.cnt = 4'h0;
      next_r.sda_oe = 1'b0;
      next_r.acked = 1'b0;
    end else if (rise_c && r.sst != S_IDLE) begin
      if (r.cnt == ebl_pkg::BIT_ACK) begin
        next_r.cnt = 4'h0;
        if (r.sst == S_READ && sda_s) next_r.sst = S_IDLE;
      end else begin
        next_r.sh = {r.sh[6:0], (r.sst == S_READ) ? 1'b0 : sda_s};
        next_r.cnt = r.cnt + 4'h1;
      end
    end else if (fall_c) begin
      case (r.sst)
        S_ADDR: begin
          if (r.cnt == ebl_pkg::BIT_ACK) begin
            if (r.sh[7:1] == r.addr) begin
              next_r.sda_oe = 1'b1;
              next_r.acked = 1'b1;
              next_r.rw = r.sh[0];
            end else begin
              next_r.sst = S_IDLE;
            end
          end else if (r.cnt == 4'h0 && r.acked) begin
            next_r.acked = 1'b0;
            next_r.sda_oe = 1'b0;
            if (r.rw == ebl_pkg::I2C_READ) begin
              next_r.sst = S_READ;
              next_r.sh = reg_read(r.regs, r.ptr);
              next_r.sda_oe = ~next_r.sh[7];
              next_r.ptr = r.ptr + 8'h1;
            end else begin
              next_r.sst = S_WRITE;
              next_r.first = 1'b1;
            end
          end
        end
        S_WRITE: begin
          if (r.cnt == ebl_pkg::BIT_ACK) begin
            next_r.sda_oe = 1'b1;
            next_r.acked = 1'b1;
            if (r.first) begin
              next_r.ptr = r.sh;
              next_r.first = 1'b0;
            end else begin
              if (r.ptr < ebl_pkg::REG_LIMIT) next_r.regs[r.ptr[4:0]] = r.sh;
              next_r.ptr = r.ptr + 8'h1;
            end
          end else if (r.cnt == 4'h0 && r.acked) begin
            next_r.sda_oe = 1'b0;
            next_r.acked = 1'b0;
          end
        end
        S_READ: begin
          if (r.cnt == ebl_pkg::BIT_ACK) begin
            next_r.sda_oe = 1'b0;
          end else if (r.cnt == 4'h0) begin
            next_r.sh = reg_read(r.regs, r.ptr);
            next_r.sda_oe = ~next_r.sh[7];
            next_r.ptr = r.ptr + 8'h1;
          end else begin
            next_r.sda_oe = ~r.sh[7];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      r <= '0;
      r.bst <= B_STRAP;
      r.sst <= S_IDLE;
      r.addr <= ebl_pkg::BOOT_SLAVE_ADDR;
      r.regs <= {ebl_pkg::REG_COUNT{ebl_pkg::REG_RESET}};
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------------------
  // link domain: bus master that reads the memory image
  // ---------------------------------------------------------------------------
  logic tick;

  always_comb begin
    next_l = l;
    tick = (l.div == DIV_LAST);
    next_l.div = (l.lst == L_IDLE || tick) ? 8'h00 : l.div + 8'h1;
    if (l.lst == L_IDLE) begin
      if (sy_l[1] != l.req_seen) begin
        next_l.req_seen = sy_l[1];
        next_l.lst = L_START;
        next_l.q = 2'h0;
        next_l.cnt = 4'h0;
        next_l.phase = 2'h0;
        next_l.idx = 5'h00;
        next_l.nack = 1'b0;
        next_l.sh = {7'(ebl_pkg::EEPROM_BASE_ADDR + {5'h00, r.sel}),
                     ebl_pkg::I2C_WRITE};
        next_l.scl_oe = 1'b1;
        next_l.sda_oe = 1'b0;
      end
    end else if (tick) begin
      next_l.q = l.q + 2'h1;
      case (l.q)
        // data moves a quarter after SCL falls, never on the clock edge
        2'h0: next_l.sda_oe = slot_sda(l);
        2'h1: next_l.scl_oe = 1'b0;
        2'h2: begin
          case (l.lst)
            L_START: next_l.sda_oe = 1'b1;
            L_STOP: next_l.sda_oe = 1'b0;
            L_TX: if (l.cnt == ebl_pkg::BIT_ACK) next_l.nack = sy_l[0];
            L_RX: if (l.cnt != ebl_pkg::BIT_ACK)
              next_l.sh = {l.sh[6:0], sy_l[0]};
            default: begin
            end
          endcase
        end
        2'h3: begin
          case (l.lst)
            L_START: begin
              next_l.lst = L_TX;
              next_l.cnt = 4'h0;
            end
            L_TX: begin
              if (l.cnt != ebl_pkg::BIT_ACK) begin
                next_l.sh = {l.sh[6:0], 1'b0};
                next_l.cnt = l.cnt + 4'h1;
              end else if (l.nack) begin
                next_l.lst = L_STOP;
              end else begin
                next_l.cnt = 4'h0;
                next_l.phase = l.phase + 2'h1;
                case (l.phase)
                  2'h0: next_l.sh = ebl_pkg::EEPROM_WORD_START;
                  2'h1: begin
                    next_l.lst = L_START;
                    next_l.sh = {7'(ebl_pkg::EEPROM_BASE_ADDR
                      + {5'h00, r.sel}), ebl_pkg::I2C_READ};
                  end
                  default: next_l.lst = L_RX;
                endcase
              end
            end
            L_RX: begin
              if (l.cnt != ebl_pkg::BIT_ACK) begin
                next_l.cnt = l.cnt + 4'h1;
              end else begin
                next_l.img[l.idx] = l.sh;
                next_l.cnt = 4'h0;
                if (l.idx == LAST_IDX) next_l.lst = L_STOP;
                else next_l.idx = l.idx + 5'h01;
              end
            end
            default: begin
              next_l.lst = L_IDLE;
              next_l.done_tgl = ~l.done_tgl;
            end
          endcase
          next_l.scl_oe = (next_l.lst != L_IDLE);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      l <= '0;
      l.lst <= L_IDLE;
    end else begin
      l <= next_l;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  logic master_en;
  assign master_en = (r.bst == B_LOAD) || (r.bst == B_WAIT);
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_O = master_en & l.scl_oe;
  assign SDA_OE_O = master_en ? l.sda_oe : r.sda_oe;
  assign EEPROM_BOOT_MODE_O = r.boot;
  assign BOOT_BUSY_O = master_en;
  assign BOOT_DONE_O = r.done;
  assign BOOT_TIMEOUT_O = r.timeout;
  assign SLAVE_ADDR_O = r.addr;
  assign CONFIG_O = r.regs;

endmodule // ebl_loader

/* sim/ebl_loader_assertions.sv */
`timescale 1ns/1ps
module ebl_loader_chk #(
  parameter int BOOT_WAIT_CYCLES = 2000,
  parameter int QDIV = 4
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic SCL_OE_O,
  input wire logic EEPROM_BOOT_MODE_O,
  input wire logic BOOT_BUSY_O,
  input wire logic BOOT_DONE_O,
  input wire logic BOOT_TIMEOUT_O,
  input wire logic [6:0] SLAVE_ADDR_O,
  input wire logic [ebl_pkg::REG_COUNT*8-1:0] CONFIG_O
);
  // ---------------------------------------------------------------------------
  // helper logic and properties
  // ---------------------------------------------------------------------------
  logic [3:0] up;
  logic [7:0] sum;
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      up <= 4'h0;
    end else if (up != 4'hf) begin
      up <= up + 4'h1;
    end
  end
  always_comb begin
    sum = 8'h00;
    for (int k = 0; k < ebl_pkg::REG_COUNT; k++) begin
      sum = sum + CONFIG_O[k*8 +: 8];
    end
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_settled;
    (BOOT_DONE_O || BOOT_TIMEOUT_O) [*3];
  endsequence
  sequence s_commit;
    $rose(BOOT_DONE_O) && CONFIG_O[8*15 +: 8] != 8'h00;
  endsequence
  chk_straps_held: assert property (up == 4'hf |-> $stable(SLAVE_ADDR_O) && $stable(EEPROM_BOOT_MODE_O))
    else $error("straps result moved after capture");
  chk_boot_addr: assert property (EEPROM_BOOT_MODE_O |-> SLAVE_ADDR_O == ebl_pkg::BOOT_SLAVE_ADDR)
    else $error("boot mode without base address");
  chk_master_gate: assert property (!EEPROM_BOOT_MODE_O |-> !SCL_OE_O)
    else $error("clock driven outside boot mode");
  chk_bus_released: assert property (s_settled |-> !SCL_OE_O)
    else $error("clock still driven after load ended");
  chk_done_sticky: assert property (BOOT_DONE_O |=> BOOT_DONE_O)
    else $error("done flag dropped");
  chk_busy_default: assert property (BOOT_BUSY_O |-> CONFIG_O == '0)
    else $error("registers changed before commit");
  chk_timeout_dflt: assert property (BOOT_TIMEOUT_O |-> CONFIG_O == '0)
    else $error("registers not default after timeout");
  chk_commit_sum: assert property (s_commit |-> sum == ebl_pkg::CHECKSUM_TARGET)
    else $error("multi device image committed with bad sum");
  chk_one_outcome: assert property (!(BOOT_DONE_O && BOOT_TIMEOUT_O))
    else $error("done and timeout together");
endmodule // ebl_loader_chk

bind ebl_loader ebl_loader_chk #(
  .BOOT_WAIT_CYCLES(BOOT_WAIT_CYCLES), .QDIV(QDIV)
) chk (
  .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .SCL_OE_O(SCL_OE_O),
  .EEPROM_BOOT_MODE_O(EEPROM_BOOT_MODE_O), .BOOT_BUSY_O(BOOT_BUSY_O),
  .BOOT_DONE_O(BOOT_DONE_O), .BOOT_TIMEOUT_O(BOOT_TIMEOUT_O),
  .SLAVE_ADDR_O(SLAVE_ADDR_O), .CONFIG_O(CONFIG_O)
);

/* sim/ebl_eeprom_model.sv */
`timescale 1ns/1ps
module ebl_eeprom_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [6:0] addr_i,
  output logic sda_oe_o
);
  // ---------------------------------------------------------------------------
  // serial memory slave; ph 0 addr, 1 word, 2 write, 3 read, 4 idle
  // ---------------------------------------------------------------------------
  logic [7:0] mem [0:26];
  logic [7:0] sh = 8'h00;
  logic [7:0] cur = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic go = 1'b0;
  int bad_left = 0;
  int bitc = 0;
  int ph = 4;
  initial sda_oe_o = 1'b0;
  always @(negedge sda_i) begin
    if (scl_i) begin
      ph = 0;
      // the clock fall that follows a start opens bit 0
      bitc = -1;
    end
  end
  always @(posedge sda_i) begin
    if (scl_i) begin
      ph = 4;
      sda_oe_o = 1'b0;
    end
  end
  always @(posedge scl_i) begin
    if (bitc < 8) begin
      sh = {sh[6:0], sda_i};
    end else begin
      go = !sda_i;
    end
  end
  always @(negedge scl_i) begin
    if (ph < 4) begin
      bitc = bitc + 1;
      if (bitc == 9) begin
        bitc = 0;
        sda_oe_o = 1'b0;
        if (ph == 3 && go) begin
          cur = mem[ptr];
          if (ptr == 8'h1a && bad_left > 0) begin
            cur = cur ^ 8'h01;
            bad_left = bad_left - 1;
          end
          ptr = ptr + 8'h01;
          sda_oe_o = !cur[7];
        end else if (ph == 3) begin
          ph = 4;
        end
      end else if (ph == 3) begin
        sda_oe_o = (bitc < 8) && !cur[7 - bitc];
      end else if (bitc == 8) begin
        if (ph == 0) begin
          ph = (sh[7:1] != addr_i) ? 4 : (sh[0] ? 3 : 1);
        end else if (ph == 1) begin
          ptr = sh;
          ph = 2;
        end
        sda_oe_o = (ph != 4);
      end
    end
  end
endmodule // ebl_eeprom_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------------------------------------------------
  // clocks, wires and design
  // ---------------------------------------------------------------------------
  localparam logic [14:0] TAB [5] = '{{8'h10, 7'h21}, {8'h12, 7'h23},
    {8'h80, 7'h33}, {8'h2a, 7'h32}, {8'ha4, 7'h48}};
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b0;
  logic [7:0] straps = 8'h00;
  logic [6:0] eep_addr = 7'h50;
  logic tb_scl_oe = 1'b0;
  logic tb_sda_oe = 1'b0;
  logic scl, sda, scl_oe, sda_oe, eep_oe, boot_mode, busy, done, tmo;
  logic [6:0] addr;
  logic [215:0] cfg, exp_cfg;
  int err_total = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  initial begin
    #1.7;
    forever #6 link_clk = ~link_clk;
  end
  assign scl = !(scl_oe || tb_scl_oe);
  assign sda = !(sda_oe || eep_oe || tb_sda_oe);
  ebl_loader #(.BOOT_WAIT_CYCLES(2000), .QDIV(4)) uut (
    .MCLK_I(clk), .RESETN_I(rst_n), .LINK_CLK_I(link_clk),
    .TWO_WIRE_HOST_MODE_I(mode),
    .STRAP_BIT_ZERO_I(straps[1:0]), .STRAP_BIT_ONE_I(straps[3:2]),
    .STRAP_BIT_TWO_I(straps[5:4]), .STRAP_BIT_THREE_I(straps[7:6]),
    .SCL_I(scl), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(),
    .SDA_OE_O(sda_oe), .EEPROM_BOOT_MODE_O(boot_mode), .BOOT_BUSY_O(busy),
    .BOOT_DONE_O(done), .BOOT_TIMEOUT_O(tmo), .SLAVE_ADDR_O(addr),
    .CONFIG_O(cfg));
  ebl_eeprom_model eep (.scl_i(scl), .sda_i(sda), .addr_i(eep_addr),
    .sda_oe_o(eep_oe));
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic chk_val(input logic [215:0] got, input logic [215:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic restart(input logic m, input logic [7:0] s);
    @(negedge clk);
    rst_n = 1'b0;
    mode = m;
    straps = s;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic wait_end(input int lim);
    int i;
    i = 0;
    while (i < lim && done !== 1'b1 && tmo !== 1'b1) begin
      @(negedge clk);
      i++;
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic load_img(input logic [7:0] cnt, input logic [7:0] seed);
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < 26; k++) begin
      eep.mem[k] = (k == 15) ? cnt : 8'(k * 7) + seed;
      s = s + eep.mem[k];
    end
    eep.mem[26] = 8'h2e - s;
    for (int k = 0; k < 27; k++) begin
      exp_cfg[k*8 +: 8] = eep.mem[k];
    end
  endtask
  task automatic tw_byte(input logic [7:0] b, output logic ack);
    for (int k = 8; k >= 0; k--) begin
      repeat (5) @(negedge clk);
      tb_sda_oe = (k > 0) && !b[k-1];
      repeat (5) @(negedge clk);
      tb_scl_oe = 1'b0;
      repeat (10) @(negedge clk);
      ack = sda;
      tb_scl_oe = 1'b1;
    end
  endtask
  task automatic tw_write(input logic [7:0] p, input logic [7:0] d);
    logic a0, a1, a2;
    tb_sda_oe = 1'b1;
    repeat (10) @(negedge clk);
    tb_scl_oe = 1'b1;
    tw_byte(8'h40, a0);
    tw_byte(p, a1);
    tw_byte(d, a2);
    repeat (5) @(negedge clk);
    tb_sda_oe = 1'b1;
    repeat (10) @(negedge clk);
    tb_scl_oe = 1'b0;
    repeat (10) @(negedge clk);
    tb_sda_oe = 1'b0;
    repeat (10) @(negedge clk);
    chk_flag(a0 | a1 | a2, 1'b0);
  endtask
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    // single device images; the last one has a spoilt check byte kept as is
    for (int sel = 0; sel < 4; sel++) begin
      load_img(8'h00, sel[7:0]);
      eep_addr = 7'h50 + 7'(sel);
      if (sel == 3) begin
        eep.bad_left = 1;
        exp_cfg[208] = ~exp_cfg[208];
      end
      restart(1'b1, {4'h0, 1'b0, sel[1], 1'b0, sel[0]});
      wait_end(20000);
      chk_flag(boot_mode, 1'b1);
      chk_flag(done, 1'b1);
      chk_val(cfg, exp_cfg);
      chk_val(216'(addr), 216'h20);
      chk_flag(scl_oe, 1'b0);
    end
    // after the load the block answers as slave 20h
    tw_write(8'h03, 8'h5a);
    exp_cfg[24 +: 8] = 8'h5a;
    chk_val(cfg, exp_cfg);
    // multi device image, first read spoilt, second good
    load_img(8'h02, 8'h09);
    eep_addr = 7'h50;
    eep.bad_left = 1;
    restart(1'b1, 8'h00);
    wait_end(40000);
    chk_flag(eep.bad_left == 0, 1'b1);
    chk_flag(done, 1'b1);
    chk_val(cfg, exp_cfg);
    // memory wired at another address stays silent
    restart(1'b1, 8'h04);
    wait_end(8000);
    chk_flag(tmo, 1'b1);
    chk_flag(done, 1'b0);
    chk_val(cfg, '0);
    foreach (TAB[i]) begin
      restart(1'b1, TAB[i][14:7]);
      repeat (20) @(negedge clk);
      chk_val(216'(addr), 216'(TAB[i][6:0]));
      chk_flag(boot_mode, 1'b0);
    end
    straps = 8'h00;
    repeat (20) @(negedge clk);
    chk_val(216'(addr), 216'(TAB[4][6:0]));
    restart(1'b0, 8'h00);
    repeat (400) @(negedge clk);
    chk_flag(boot_mode, 1'b0);
    chk_flag(scl_oe, 1'b0);
    print_verdict;
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    print_verdict;
  end
endmodule // tb_top
